// file: hdl/wbbf_pkg.sv
package wbbf_pkg;

    // ==========================================
    // sequencer states
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_MWR_LO,
        ST_MWR_HI,
        ST_MRD_HI,
        ST_MRD_LO,
        ST_SWR_WAIT,
        ST_SRD_WAIT,
        ST_DONE
    } wbbf_state_t;

    // ==========================================
    // byte lanes as seen on byte_select
    localparam logic BSEL_LO = 1'b0;
    localparam logic BSEL_HI = 1'b1;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // ==========================================
    // pin inputs after the two-flop synchroniser
    typedef struct packed
    {
        logic mreq;
        logic mrd;
        logic grant;
        logic lock;
        logic ack;
        logic sel;
        logic rd;
        logic wr;
        logic bsel;
        logic [7:0] bus_data;
        logic [15:0] per_data;
    } wbbf_pins_t;

    localparam int PINS_W = $bits(wbbf_pins_t);
    localparam logic [PINS_W-1:0] PINS_RST = '0;

endpackage

// file: hdl/wbbf_funnel.sv
`timescale 1ns/100ps
module wbbf_funnel
(
    input wire logic SYS_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic PER_MREQ_IN,
    input wire logic PER_MRD_IN,
    input wire logic [15:0] PER_DATA_IN,
    output logic [15:0] PER_DATA_OUT,
    output logic PER_LOAD_OUT,
    output logic PER_FETCH_OUT,
    output logic PER_HOLD_OUT,
    input wire logic BUS_GRANT_IN,
    input wire logic BUS_LOCK_IN,
    output logic BUS_REQ_OUT,
    input wire logic BUS_ACK_IN,
    output logic BUS_RD_N_OUT,
    output logic BUS_WR_N_OUT,
    input wire logic BUS_BSEL_IN,
    output logic BUS_BSEL_OUT,
    output logic BUS_BSEL_OE_OUT,
    input wire logic [7:0] BUS_DATA_IN,
    output logic [7:0] BUS_DATA_OUT,
    output logic BUS_DATA_OE_OUT,
    input wire logic CPU_SEL_IN,
    input wire logic CPU_RD_IN,
    input wire logic CPU_WR_IN
);

    // ==========================================
    // state
    typedef struct packed
    {
        logic [wbbf_pkg::PINS_W-1:0] sync1;
        wbbf_pkg::wbbf_pins_t pin;
        logic rd_prev;
        logic wr_prev;
        wbbf_pkg::wbbf_state_t state;
        logic strobe;
        logic bsel;
        logic hold;
        // master request not yet seen withdrawn after a finished transfer
        logic spent;
        logic load;
        logic fetch;
        logic [7:0] latch;
        logic [7:0] bus_data;
        logic [15:0] per_data;
    } wbbf_regs_t;

    wbbf_regs_t r_q;
    wbbf_regs_t r_d;
    wbbf_pkg::wbbf_pins_t raw;
    logic rd_edge;
    logic wr_edge;
    logic master;
    logic slave_ok;

    assign raw = '{mreq: PER_MREQ_IN, mrd: PER_MRD_IN, grant: BUS_GRANT_IN,
                   lock: BUS_LOCK_IN, ack: BUS_ACK_IN, sel: CPU_SEL_IN,
                   rd: CPU_RD_IN, wr: CPU_WR_IN, bsel: BUS_BSEL_IN,
                   bus_data: BUS_DATA_IN, per_data: PER_DATA_IN};

    assign rd_edge = r_q.pin.rd && !r_q.rd_prev && r_q.pin.sel;
    assign wr_edge = r_q.pin.wr && !r_q.wr_prev && r_q.pin.sel;
    assign master = r_q.state inside {wbbf_pkg::ST_MWR_LO, wbbf_pkg::ST_MWR_HI,
                                      wbbf_pkg::ST_MRD_HI, wbbf_pkg::ST_MRD_LO};
    // slave edges only count outside master work
    assign slave_ok = !master;

    // ==========================================
    // next state
    always_comb
    begin
        r_d = r_q;
        r_d.sync1 = raw;
        r_d.pin = r_q.sync1;
        r_d.rd_prev = r_q.pin.rd;
        r_d.wr_prev = r_q.pin.wr;
        r_d.load = 1'b0;
        r_d.fetch = 1'b0;
        unique case (r_q.state)
            wbbf_pkg::ST_IDLE:
            begin
                r_d.hold = 1'b0;
                // synced request lags the hold release by two cycles, so wait to see it drop
                if (!r_q.pin.mreq)
                begin
                    r_d.spent = 1'b0;
                end
                // grant is honoured only while the processor leaves arbitration open
                if (r_q.pin.mreq && r_q.pin.grant && !r_q.pin.lock && !r_q.spent)
                begin
                    r_d.hold = 1'b1;
                    r_d.strobe = 1'b1;
                    if (r_q.pin.mrd)
                    begin
                        r_d.state = wbbf_pkg::ST_MRD_HI;
                        r_d.bsel = wbbf_pkg::BSEL_HI;
                    end
                    else
                    begin
                        r_d.state = wbbf_pkg::ST_MWR_LO;
                        r_d.bsel = wbbf_pkg::BSEL_LO;
                        r_d.bus_data = r_q.pin.per_data[7:0];
                    end
                end
                else if (slave_ok && wr_edge && r_q.pin.bsel == wbbf_pkg::BSEL_HI)
                begin
                    r_d.latch = r_q.pin.bus_data;
                    r_d.state = wbbf_pkg::ST_SWR_WAIT;
                end
                else if (slave_ok && rd_edge && r_q.pin.bsel == wbbf_pkg::BSEL_LO)
                begin
                    // one peripheral read serves both byte reads
                    r_d.fetch = 1'b1;
                    r_d.bus_data = r_q.pin.per_data[7:0];
                    r_d.latch = r_q.pin.per_data[15:8];
                    r_d.state = wbbf_pkg::ST_SRD_WAIT;
                end
            end
            wbbf_pkg::ST_MWR_LO, wbbf_pkg::ST_MWR_HI,
            wbbf_pkg::ST_MRD_HI, wbbf_pkg::ST_MRD_LO:
            begin
                if (r_q.strobe && r_q.pin.ack)
                begin
                    r_d.strobe = 1'b0;
                    if (r_q.state == wbbf_pkg::ST_MRD_HI)
                    begin
                        r_d.latch = r_q.pin.bus_data;
                    end
                    else if (r_q.state == wbbf_pkg::ST_MRD_LO)
                    begin
                        // second byte goes straight in, next to the latch
                        r_d.per_data = {r_q.latch, r_q.pin.bus_data};
                        r_d.load = 1'b1;
                    end
                end
                else if (!r_q.strobe && !r_q.pin.ack)
                begin
                    // wait for ack to drop so byte cycles never merge
                    unique case (r_q.state)
                        wbbf_pkg::ST_MWR_LO:
                        begin
                            r_d.state = wbbf_pkg::ST_MWR_HI;
                            r_d.bsel = wbbf_pkg::BSEL_HI;
                            r_d.bus_data = r_q.pin.per_data[15:8];
                            r_d.strobe = 1'b1;
                        end
                        wbbf_pkg::ST_MRD_HI:
                        begin
                            r_d.state = wbbf_pkg::ST_MRD_LO;
                            r_d.bsel = wbbf_pkg::BSEL_LO;
                            r_d.strobe = 1'b1;
                        end
                        default:
                        begin
                            r_d.state = wbbf_pkg::ST_DONE;
                            r_d.hold = 1'b0;
                            r_d.spent = 1'b1;
                        end
                    endcase
                end
            end
            wbbf_pkg::ST_SWR_WAIT:
            begin
                // master requests are not looked at here
                if (wr_edge && r_q.pin.bsel == wbbf_pkg::BSEL_LO)
                begin
                    r_d.per_data = {r_q.latch, r_q.pin.bus_data};
                    r_d.load = 1'b1;
                    r_d.state = wbbf_pkg::ST_DONE;
                end
            end
            wbbf_pkg::ST_SRD_WAIT:
            begin
                if (rd_edge && r_q.pin.bsel == wbbf_pkg::BSEL_HI)
                begin
                    r_d.bus_data = r_q.latch;
                    r_d.state = wbbf_pkg::ST_DONE;
                end
            end
            wbbf_pkg::ST_DONE:
            begin
                r_d.hold = 1'b0;
                r_d.state = wbbf_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            r_q <= '{sync1: wbbf_pkg::PINS_RST, pin: wbbf_pkg::PINS_RST,
                     rd_prev: 1'b0, wr_prev: 1'b0, state: wbbf_pkg::ST_IDLE,
                     strobe: 1'b0, bsel: wbbf_pkg::BSEL_LO, hold: 1'b0, spent: 1'b0,
                     load: 1'b0, fetch: 1'b0, latch: wbbf_pkg::BYTE_RST,
                     bus_data: wbbf_pkg::BYTE_RST, per_data: wbbf_pkg::WORD_RST};
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // ==========================================
    // outputs
    assign PER_DATA_OUT = r_q.per_data;
    assign PER_LOAD_OUT = r_q.load;
    assign PER_FETCH_OUT = r_q.fetch;
    assign PER_HOLD_OUT = r_q.hold;
    assign BUS_REQ_OUT = r_q.pin.mreq && !r_q.pin.lock && !r_q.spent
                         && r_q.state == wbbf_pkg::ST_IDLE;
    assign BUS_RD_N_OUT = !(r_q.strobe && (r_q.state == wbbf_pkg::ST_MRD_HI
                          || r_q.state == wbbf_pkg::ST_MRD_LO));
    assign BUS_WR_N_OUT = !(r_q.strobe && (r_q.state == wbbf_pkg::ST_MWR_LO
                          || r_q.state == wbbf_pkg::ST_MWR_HI));
    assign BUS_BSEL_OUT = r_q.bsel;
    assign BUS_BSEL_OE_OUT = master;
    // drive during master writes and processor reads, transceiver style
    assign BUS_DATA_OUT = r_q.bus_data;
    assign BUS_DATA_OE_OUT = (r_q.state == wbbf_pkg::ST_MWR_LO)
                             || (r_q.state == wbbf_pkg::ST_MWR_HI)
                             || (r_q.pin.rd && r_q.pin.sel && !master);

    // ==========================================
    // checks
    AST_IDLE_AFTER_RESET: assert property (@(posedge SYS_CLK_IN)
        $rose(ARST_N_IN) |-> r_q.state == wbbf_pkg::ST_IDLE)
        else $error("sequencer not idle after reset");
    AST_LO_BEFORE_HI: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        r_q.state == wbbf_pkg::ST_MWR_HI |-> $past(r_q.state) inside
        {wbbf_pkg::ST_MWR_LO, wbbf_pkg::ST_MWR_HI})
        else $error("high byte written before low byte");
    AST_WORD_ASSEMBLED: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        $rose(r_q.load) |-> r_q.per_data[15:8] == $past(r_q.latch))
        else $error("assembled word lacks latched byte");
    AST_NO_SLAVE_IN_MASTER: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        master |=> !(r_q.state inside {wbbf_pkg::ST_SWR_WAIT, wbbf_pkg::ST_SRD_WAIT}))
        else $error("slave access entered during master transfer");
    AST_NO_MASTER_IN_SLAVE: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        r_q.state inside {wbbf_pkg::ST_SWR_WAIT, wbbf_pkg::ST_SRD_WAIT}
        |=> !master && !BUS_REQ_OUT)
        else $error("master started inside slave access");
    AST_HOLD_THROUGH: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        master |-> PER_HOLD_OUT)
        else $error("hold dropped during funnelling");
    AST_LOCK_BLOCKS: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        r_q.pin.lock && r_q.state == wbbf_pkg::ST_IDLE |=> !master)
        else $error("master started while arbitration locked");
    AST_BSEL_DRIVE: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        BUS_BSEL_OE_OUT |-> (BUS_BSEL_OUT == (r_q.state inside
        {wbbf_pkg::ST_MWR_HI, wbbf_pkg::ST_MRD_HI})))
        else $error("byte_select wrong for lane");
    // a second load would need a fresh strobe, so the strobe must be gone as well
    AST_ONE_LOAD: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        r_q.load |=> !r_q.load && !r_q.strobe
        ##1 !r_q.load)
        else $error("peripheral load not single per word");
    AST_RELEASE: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        r_q.state == wbbf_pkg::ST_DONE |-> !PER_HOLD_OUT ##1
        r_q.state == wbbf_pkg::ST_IDLE)
        else $error("no release through idle");
    AST_NO_REARM: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        r_q.spent |=> !master)
        else $error("stale master request restarted the sequencer");
    AST_FETCH_ENTRY: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        r_q.fetch |-> r_q.state == wbbf_pkg::ST_SRD_WAIT && !PER_HOLD_OUT)
        else $error("peripheral fetch outside slave read");
    AST_READ_LATCH: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        r_q.fetch |-> {r_q.latch, r_q.bus_data} == $past(r_q.pin.per_data))
        else $error("slave read word not split into latch and bus byte");
    AST_STROBES_APART: assert property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        (!BUS_RD_N_OUT || !BUS_WR_N_OUT) |->
        PER_HOLD_OUT && BUS_BSEL_OE_OUT && (BUS_RD_N_OUT || BUS_WR_N_OUT))
        else $error("bus strobe outside a held master cycle");
    CVR_MASTER_READ: cover property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        r_q.state == wbbf_pkg::ST_MRD_LO ##[1:50] r_q.load);
    CVR_MASTER_WRITE: cover property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        r_q.state == wbbf_pkg::ST_MWR_HI ##[1:50] r_q.state == wbbf_pkg::ST_DONE);
    CVR_SLAVE_WRITE: cover property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        r_q.state == wbbf_pkg::ST_SWR_WAIT ##[1:50] r_q.load);
    CVR_SLAVE_READ: cover property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        r_q.fetch ##[1:50] r_q.state == wbbf_pkg::ST_DONE);
    CVR_SLAVE_REFUSED: cover property (@(posedge SYS_CLK_IN) disable iff (!ARST_N_IN)
        master && wr_edge);

endmodule // wbbf_funnel

// file: testbench/wbbf_sys_model.sv
`timescale 1ns/100ps
// ==========================================
// system bus memory answering block-mastered byte cycles
module wbbf_sys_model
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic bsel_in,
    input wire logic [7:0] wdata_in,
    input wire logic [15:0] rword_in,
    input wire logic [3:0] delay_in,
    output logic ack_out,
    output logic [7:0] rdata_out,
    output logic [17:0] log_out,
    output logic [3:0] count_out
);
    logic [3:0] wait_q;
    logic [7:0] last_q;
    logic [7:0] byte_w;

    assign byte_w = bsel_in ? rword_in[15:8] : rword_in[7:0];
    // released bus shows the inverse of the last byte, never a kind constant
    assign rdata_out = rd_n_in ? ~last_q : byte_w;

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ack_out <= 1'b0;
            wait_q <= 4'h0;
            last_q <= 8'h00;
            log_out <= 18'h00000;
            count_out <= 4'h0;
        end
        else if (rd_n_in && wr_n_in)
        begin
            // four-phase: ack falls only once the strobe is gone
            ack_out <= 1'b0;
            wait_q <= 4'h0;
        end
        else if (!ack_out && wait_q == delay_in)
        begin
            ack_out <= 1'b1;
            count_out <= count_out + 4'h1;
            log_out <= {log_out[8:0], bsel_in, rd_n_in ? wdata_in : byte_w};
            last_q <= rd_n_in ? wdata_in : byte_w;
        end
        else if (!ack_out)
            wait_q <= wait_q + 4'h1;
    end
endmodule // wbbf_sys_model

// file: testbench/tb_wbbf_funnel.sv
`timescale 1ns/100ps
module tb_wbbf_funnel;
    logic clk, rst_n, mreq, mrd, grant, lock, sel, rd, wr, cbsel;
    logic [15:0] pdata, rword, pout, lword;
    logic [7:0] cdata, bout, mdata;
    logic [3:0] dly, cnt;
    logic load, fetch, hold, req, rd_n, wr_n, bsel_o, bsel_oe, ack, doe;
    logic [17:0] log_w;
    int bad_count = 0;
    int cmp_count = 0;
    int loads = 0;
    int fetches = 0;
    wire bsel_w = bsel_oe ? bsel_o : cbsel;
    wire [7:0] bin = (wr && rd_n) ? cdata : mdata;

    wbbf_funnel uut
    (
        .SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .PER_MREQ_IN(mreq), .PER_MRD_IN(mrd),
        .PER_DATA_IN(pdata), .PER_DATA_OUT(pout), .PER_LOAD_OUT(load),
        .PER_FETCH_OUT(fetch), .PER_HOLD_OUT(hold), .BUS_GRANT_IN(grant),
        .BUS_LOCK_IN(lock), .BUS_REQ_OUT(req), .BUS_ACK_IN(ack), .BUS_RD_N_OUT(rd_n),
        .BUS_WR_N_OUT(wr_n), .BUS_BSEL_IN(bsel_w), .BUS_BSEL_OUT(bsel_o),
        .BUS_BSEL_OE_OUT(bsel_oe), .BUS_DATA_IN(bin), .BUS_DATA_OUT(bout),
        .BUS_DATA_OE_OUT(doe), .CPU_SEL_IN(sel), .CPU_RD_IN(rd), .CPU_WR_IN(wr)
    );

    wbbf_sys_model sys
    (
        .clk_in(clk), .arst_n_in(rst_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
        .bsel_in(bsel_w), .wdata_in(bout), .rword_in(rword), .delay_in(dly),
        .ack_out(ack), .rdata_out(mdata), .log_out(log_w), .count_out(cnt)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (load === 1'b1)
        begin
            loads++;
            lword <= pout;
        end
        if (fetch === 1'b1)
            fetches++;
    end

    // ==========================================
    // helpers
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wait_for(input logic lvl);
        int i;
        i = 0;
        while (hold !== lvl && i < 300)
        begin
            @(negedge clk);
            i++;
        end
        chk(18'(hold), 18'(lvl));
    endtask

    task automatic master(input logic dir, input logic [15:0] w);
        logic [3:0] c0;
        @(negedge clk);
        mrd = dir;
        pdata = w;
        mreq = 1'b1;
        grant = 1'b1;
        c0 = cnt;
        wait_for(1'b1);
        wait_for(1'b0);
        chk(18'(4'(cnt - c0)), 18'h2);
        mreq = 1'b0;
        grant = 1'b0;
        cyc(4);
    endtask

    // slave access held long enough for the input synchronisers
    task automatic cpu(input logic r, input logic b, input logic [7:0] d);
        @(negedge clk);
        sel = 1'b1;
        cbsel = b;
        cdata = d;
        rd = r;
        wr = !r;
        cyc(5);
        if (r)
            chk({9'h0, doe, bout}, {9'h0, 1'b1, d});
        rd = 1'b0;
        wr = 1'b0;
        sel = 1'b0;
        cyc(4);
    endtask

    // ==========================================
    // scenarios
    task automatic t_mwrite;
        dly = 4'h0;
        master(1'b0, 16'h3c5a);
        chk(log_w, {1'b0, 8'h5a, 1'b1, 8'h3c});
        chk(18'(bsel_oe), 18'h0);
        dly = 4'h2;
    endtask

    task automatic t_mread;
        int l0;
        l0 = loads;
        rword = 16'hc381;
        master(1'b1, 16'h0000);
        chk(18'(loads - l0), 18'h1);
        chk(18'(lword), 18'hc381);
        chk(log_w, {1'b1, 8'hc3, 1'b0, 8'h81});
    endtask

    task automatic t_swrite;
        int l0;
        l0 = loads;
        cpu(1'b0, 1'b0, 8'h34);
        chk(18'(loads - l0), 18'h0);
        cpu(1'b0, 1'b1, 8'h12);
        mrd = 1'b1;
        mreq = 1'b1;
        grant = 1'b1;
        cyc(6);
        chk(18'(hold), 18'h0);
        cpu(1'b0, 1'b0, 8'h34);
        chk(18'(lword), 18'h1234);
        wait_for(1'b1);
        wait_for(1'b0);
        mreq = 1'b0;
        grant = 1'b0;
        cyc(4);
        chk(18'(lword), 18'hc381);
    endtask

    task automatic t_sread;
        int f0;
        f0 = fetches;
        pdata = 16'hbeef;
        mrd = 1'b0;
        lock = 1'b1;
        mreq = 1'b1;
        grant = 1'b1;
        cpu(1'b1, 1'b0, 8'hef);
        cpu(1'b1, 1'b1, 8'hbe);
        chk({16'h0, req, hold}, 18'h0);
        chk(18'(fetches - f0), 18'h1);
        lock = 1'b0;
        master(1'b0, 16'hbeef);
        chk(log_w, {1'b0, 8'hef, 1'b1, 8'hbe});
    endtask

    task automatic t_interlock;
        int l0;
        l0 = loads;
        dly = 4'h8;
        rword = 16'h5aa5;
        fork
            master(1'b1, 16'h0000);
            begin
                wait_for(1'b1);
                cpu(1'b0, 1'b1, 8'h77);
                cpu(1'b0, 1'b0, 8'h66);
            end
        join
        chk(18'(loads - l0), 18'h1);
        chk(18'(lword), 18'h5aa5);
    endtask

    // ==========================================
    // main sequence and watchdog
    initial
    begin
        {mreq, mrd, grant, lock, sel, rd, wr, cbsel} = 8'h00;
        pdata = 16'h0000;
        rword = 16'h0000;
        cdata = 8'h00;
        dly = 4'h2;
        rst_n = 1'b0;
        cyc(10);
        chk({10'h0, hold, req, rd_n, wr_n, bsel_oe, doe, load, fetch}, 18'h30);
        rst_n = 1'b1;
        cyc(3);
        t_mwrite();
        t_mread();
        t_swrite();
        t_sread();
        t_interlock();
        test_done();
    end

    initial
    begin
        // whole run needs a few hundred cycles
        repeat (5000) @(posedge clk);
        bad_count++;
        test_done();
    end
endmodule // tb_wbbf_funnel
